// >>> hw/dmc_pkg.sv
// Shared constants and types of the descriptor channel controller
package dmc_pkg;

  // ------------------------------------------------------------------
  // Descriptor words, byte address is four times the word index
  // ------------------------------------------------------------------
  localparam int          DMC_NDESC    = 8;
  localparam int          W_SRC        = 0;
  localparam int          W_DST        = 1;
  localparam int          W_OFF        = 2;
  localparam int          W_NBYTES     = 3;
  localparam int          W_MLOFF      = 4;
  localparam int          W_ITER       = 5;
  localparam int          W_CSR        = 6;
  localparam int          W_SGA        = 7;

  // ------------------------------------------------------------------
  // Channel registers outside the descriptor
  // ------------------------------------------------------------------
  localparam logic [7:0]  A_CTRL       = 8'h20;
  localparam logic [7:0]  A_STATUS     = 8'h24;
  localparam logic [7:0]  A_MASK       = 8'h28;
  localparam logic [7:0]  A_REMAIN     = 8'h2c;
  localparam int          CTRL_ERQ     = 0;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int          CSR_START    = 0;
  localparam int          CSR_INTMAJ   = 1;
  localparam int          CSR_INTHALF  = 2;
  localparam int          CSR_AUTOSTOP = 3;
  localparam int          CSR_ESG      = 4;
  localparam int          CSR_LTYPE    = 5;
  localparam int          CSR_BW       = 7;
  localparam int          CSR_LCH      = 9;
  localparam int          CSR_SMOD     = 12;
  localparam int          CSR_DMOD     = 17;
  localparam int          CSR_SIZE     = 22;
  localparam int          DMC_LCH_W    = 3;
  localparam int          DMC_MOD_W    = 5;
  localparam logic [31:0] CSR_LINK_MSK = 32'h0000_0e60;
  localparam int          OFF_SRC      = 0;
  localparam int          OFF_DST      = 16;
  localparam int          OFF_W        = 16;
  localparam int          ML_SRC_EN    = 31;
  localparam int          ML_DST_EN    = 30;
  localparam int          ML_W         = 20;
  localparam int          ITER_CUR     = 0;
  localparam int          ITER_BEG     = 16;
  localparam int          ITER_W       = 16;

  // ------------------------------------------------------------------
  // Status bits, encodings, timing
  // ------------------------------------------------------------------
  localparam int          ST_MAJOR     = 0;
  localparam int          ST_HALF      = 1;
  localparam int          ST_DESC_ERR  = 2;
  localparam int          ST_SRC_ERR   = 3;
  localparam int          ST_DONE      = 4;
  localparam int          ST_W         = 5;
  localparam logic [1:0]  LINK_TYPE_NONE  = 2'h0;
  localparam logic [1:0]  LINK_TYPE_MINOR = 2'h1;
  localparam logic [1:0]  LINK_TYPE_MAJOR = 2'h2;
  localparam logic [1:0]  STALL_NONE         = 2'h0;
  localparam logic [1:0]  STALL_FOUR_CYCLES  = 2'h2;
  localparam logic [1:0]  STALL_EIGHT_CYCLES = 2'h3;
  localparam logic [3:0]  STALL4_CNT   = 4'h4;
  localparam logic [3:0]  STALL8_CNT   = 4'h8;
  localparam logic [1:0]  SIZE_MAX     = 2'h2;
  localparam int          DMC_DESC_ALIGN = 32;

  typedef enum logic [2:0] {
    S_IDLE, S_RD, S_WR, S_STALL, S_MEND, S_SG
  } dmc_state_t;

endpackage

// >>> hw/dmc_addr_step.sv
// Address update with signed offset and modulo wrap
`timescale 1ns/1ps

module dmc_addr_step #(
  parameter int AW = 32,
  parameter int MW = 5
) (
  input  wire logic [AW-1:0] base,
  input  wire logic [AW-1:0] offset,
  input  wire logic [MW-1:0] modulo,
  output logic      [AW-1:0] result
);
  logic [AW-1:0] sum;
  logic [AW-1:0] hold;

  if (AW < 8 || (1 << MW) > AW)
  begin : g_bad
    $error("dmc_addr_step: modulo range exceeds address width");
  end

  assign sum  = base + offset;
  // Zero modulo keeps the plain sum; otherwise upper bits stay put
  assign hold = (modulo == '0) ? '0 : ({AW{1'b1}} << modulo);
  assign result = (base & hold) | (sum & ~hold);
endmodule // dmc_addr_step

// >>> hw/dmc_channel.sv
// Descriptor driven DMA channel with APB registers and bus master port
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps

module dmc_channel
#(
  parameter int DESC_ALIGN = dmc_pkg::DMC_DESC_ALIGN
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          hw_req,
  input  wire logic                          link_in,
  output logic                               m_req,
  output logic                               m_we,
  output logic      [31:0]                   m_addr,
  output logic      [31:0]                   m_wdata,
  output logic      [1:0]                    m_size,
  input  wire logic                          m_ack,
  input  wire logic [31:0]                   m_rdata,
  output logic                               link_trig,
  output logic      [dmc_pkg::DMC_LCH_W-1:0] link_ch,
  output logic                               busy,
  output logic                               irq
);
  import dmc_pkg::*;

  if (DESC_ALIGN < 4 || (DESC_ALIGN & (DESC_ALIGN - 1)) != 0)
  begin : g_bad_align
    $error("dmc_channel: DESC_ALIGN must be a power of two of 4 or more");
  end

  localparam logic [31:0] ALIGN_MSK = 32'(DESC_ALIGN - 1);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [DMC_NDESC-1:0][31:0] desc;
    dmc_state_t                 st;
    dmc_state_t                 nxt;
    logic                       erq;
    logic [ST_W-1:0]            status;
    logic [ST_W-1:0]            mask;
    logic                       from_hw;
    logic [31:0]                bleft;
    logic [31:0]                data;
    logic [31:0]                prdata;
    logic                       m_req;
    logic                       m_we;
    logic [31:0]                m_addr;
    logic [31:0]                m_wdata;
    logic [3:0]                 stall;
    logic [2:0]                 sgi;
    logic                       link_trig;
  } dmc_regs_t;

  dmc_regs_t q;
  dmc_regs_t d;

  // ------------------------------------------------------------------
  // Descriptor field views
  // ------------------------------------------------------------------
  logic [31:0]           csr;
  logic [1:0]            ltype;
  logic [1:0]            bw;
  logic [1:0]            size;
  logic [31:0]           sz_b;
  logic [ITER_W-1:0]     cur_iter;
  logic [ITER_W-1:0]     biter;
  logic [ITER_W-1:0]     cur_iter_dec;
  logic [31:0]           src_step_sx;
  logic [31:0]           dst_step_sx;
  logic [31:0]           mloff_sx;
  logic [31:0]           src_off;
  logic [31:0]           dst_off;
  logic [31:0]           src_next;
  logic [31:0]           dst_next;
  logic [47:0]           remain_full;
  logic                  paused;
  logic                  go;
  logic                  stall_en;
  logic [3:0]            stall_ld;

  assign csr       = q.desc[W_CSR];
  assign ltype     = csr[CSR_LTYPE +: 2];
  assign bw        = csr[CSR_BW +: 2];
  assign size      = (csr[CSR_SIZE +: 2] > SIZE_MAX) ? SIZE_MAX
                                                     : csr[CSR_SIZE +: 2];
  assign sz_b      = 32'h1 << size;
  assign cur_iter     = q.desc[W_ITER][ITER_CUR +: ITER_W];
  assign biter        = q.desc[W_ITER][ITER_BEG +: ITER_W];
  assign cur_iter_dec = cur_iter - 16'h1;
  assign src_step_sx  = 32'($signed(q.desc[W_OFF][OFF_SRC +: OFF_W]));
  assign dst_step_sx  = 32'($signed(q.desc[W_OFF][OFF_DST +: OFF_W]));
  assign mloff_sx     = 32'($signed(q.desc[W_MLOFF][ML_W-1:0]));

  // Minor offset only in the loop end state, where enabled
  assign src_off = (q.st != S_MEND) ? src_step_sx
                 : q.desc[W_MLOFF][ML_SRC_EN] ? mloff_sx : '0;
  assign dst_off = (q.st != S_MEND) ? dst_step_sx
                 : q.desc[W_MLOFF][ML_DST_EN] ? mloff_sx : '0;

  dmc_addr_step #(
    .AW     (32),
    .MW     (DMC_MOD_W)
  ) u_src_step (
    .base   (q.desc[W_SRC]),
    .offset (src_off),
    .modulo (csr[CSR_SMOD +: DMC_MOD_W]),
    .result (src_next)
  );

  dmc_addr_step #(
    .AW     (32),
    .MW     (DMC_MOD_W)
  ) u_dst_step (
    .base   (q.desc[W_DST]),
    .offset (dst_off),
    .modulo (csr[CSR_DMOD +: DMC_MOD_W]),
    .result (dst_next)
  );

  assign remain_full = cur_iter * q.desc[W_NBYTES];
  // A request-driven minor loop halts between accesses while disabled
  assign paused   = q.from_hw & ~q.erq;
  assign go       = (q.erq & hw_req) | csr[CSR_START] | link_in;
  assign stall_en = (bw == STALL_FOUR_CYCLES)
                  | (bw == STALL_EIGHT_CYCLES);
  assign stall_ld = ((bw == STALL_EIGHT_CYCLES) ? STALL8_CNT
                                                : STALL4_CNT) - 4'h1;

  // ------------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------------
  logic        ap_setup;
  logic        ap_acc;
  logic        ap_desc;
  logic        ap_bad;
  logic [2:0]  ap_idx;
  logic [31:0] rd_mux;

  assign ap_setup = psel & ~penable;
  assign ap_acc   = psel & penable;
  assign ap_idx   = paddr[4:2];
  assign ap_desc  = (paddr[7:5] == 3'h0);
  assign ap_bad   = (paddr[1:0] != 2'h0)
                  | ~(ap_desc | paddr == A_CTRL | paddr == A_STATUS
                      | paddr == A_MASK | paddr == A_REMAIN);

  always_comb
  begin
    rd_mux = '0;
    if (ap_desc)
      rd_mux = q.desc[ap_idx];
    else if (paddr == A_CTRL)
      rd_mux[CTRL_ERQ] = q.erq;
    else if (paddr == A_STATUS)
      rd_mux[ST_W-1:0] = q.status;
    else if (paddr == A_MASK)
      rd_mux[ST_W-1:0] = q.mask;
    else if (paddr == A_REMAIN)
      rd_mux = remain_full[31:0];
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.link_trig = 1'b0;
    if (ap_setup)
      d.prdata = rd_mux;

    // Software writes first, so hardware events below win a clear
    if (ap_acc && pwrite && !ap_bad)
    begin
      if (ap_desc)
      begin
        d.desc[ap_idx] = pwdata;
        // Link setting is frozen while the completion flag stands
        if (ap_idx == 3'(W_CSR) && q.status[ST_DONE])
          d.desc[W_CSR] = (pwdata & ~CSR_LINK_MSK)
                        | (csr & CSR_LINK_MSK);
      end
      else if (paddr == A_CTRL)
        d.erq = pwdata[CTRL_ERQ];
      else if (paddr == A_STATUS)
        d.status = q.status & ~pwdata[ST_W-1:0];
      else if (paddr == A_MASK)
        d.mask = pwdata[ST_W-1:0];
    end

    case (q.st)
      S_IDLE:
      begin
        if (go)
        begin
          d.from_hw = ~(csr[CSR_START] | link_in);
          d.desc[W_CSR][CSR_START] = 1'b0;
          d.bleft = q.desc[W_NBYTES];
          d.st = S_RD;
        end
      end
      S_RD:
      begin
        if (!q.m_req)
        begin
          if ((q.desc[W_SRC] & (sz_b - 32'h1)) != '0)
          begin
            d.status[ST_SRC_ERR] = 1'b1;
            d.erq = 1'b0;
            d.st = S_IDLE;
          end
          else if (!paused)
          begin
            d.m_req  = 1'b1;
            d.m_we   = 1'b0;
            d.m_addr = q.desc[W_SRC];
          end
        end
        else if (m_ack)
        begin
          d.m_req = 1'b0;
          d.data = m_rdata;
          d.desc[W_SRC] = src_next;
          d.nxt = S_WR;
          d.st = stall_en ? S_STALL : S_WR;
          d.stall = stall_ld;
        end
      end
      S_WR:
      begin
        if (!q.m_req)
        begin
          if (!paused)
          begin
            d.m_req   = 1'b1;
            d.m_we    = 1'b1;
            d.m_addr  = q.desc[W_DST];
            d.m_wdata = q.data;
          end
        end
        else if (m_ack)
        begin
          d.m_req = 1'b0;
          d.desc[W_DST] = dst_next;
          d.bleft = (q.bleft > sz_b) ? q.bleft - sz_b : '0;
          d.nxt = (q.bleft > sz_b) ? S_RD : S_MEND;
          d.st = stall_en ? S_STALL : d.nxt;
          d.stall = stall_ld;
        end
      end
      S_STALL:
      begin
        if (q.stall == 4'h0)
          d.st = q.nxt;
        else
          d.stall = q.stall - 4'h1;
      end
      S_MEND:
      begin
        d.desc[W_SRC] = src_next;
        d.desc[W_DST] = dst_next;
        d.desc[W_ITER][ITER_CUR +: ITER_W] = cur_iter_dec;
        d.st = S_IDLE;
        if (ltype == LINK_TYPE_MINOR)
          d.link_trig = 1'b1;
        if (csr[CSR_INTHALF] && cur_iter_dec == (biter >> 1))
          d.status[ST_HALF] = 1'b1;
        if (cur_iter_dec == '0)
        begin
          d.status[ST_DONE] = 1'b1;
          if (csr[CSR_INTMAJ])
            d.status[ST_MAJOR] = 1'b1;
          if (ltype == LINK_TYPE_MAJOR)
            d.link_trig = 1'b1;
          if (csr[CSR_AUTOSTOP])
            d.erq = 1'b0;
          if (!csr[CSR_ESG])
            d.desc[W_ITER][ITER_CUR +: ITER_W] = biter;
          else if ((q.desc[W_SGA] & ALIGN_MSK) != '0)
            d.status[ST_DESC_ERR] = 1'b1;
          else
          begin
            d.sgi = 3'h0;
            d.st = S_SG;
          end
        end
      end
      S_SG:
      begin
        // Next descriptor address is word 7, replaced only at the end
        if (!q.m_req)
        begin
          d.m_req  = 1'b1;
          d.m_we   = 1'b0;
          d.m_addr = q.desc[W_SGA] + {27'h0, q.sgi, 2'h0};
        end
        else if (m_ack)
        begin
          d.m_req = 1'b0;
          d.desc[q.sgi] = m_rdata;
          d.sgi = q.sgi + 3'h1;
          if (q.sgi == 3'(DMC_NDESC - 1))
            d.st = S_IDLE;
        end
      end
      default:
        d.st = S_IDLE;
    endcase
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  // Zero wait state: read data were latched in the setup cycle
  assign prdata    = q.prdata;
  assign pready    = ap_acc;
  assign pslverr   = ap_acc & ap_bad;
  assign m_req     = q.m_req;
  assign m_we      = q.m_we;
  assign m_addr    = q.m_addr;
  assign m_wdata   = q.m_wdata;
  assign m_size    = size;
  assign link_trig = q.link_trig;
  assign link_ch   = csr[CSR_LCH +: DMC_LCH_W];
  assign busy      = (q.st != S_IDLE);
  assign irq       = |(q.status & q.mask);
endmodule // dmc_channel

// >>> testbench/dmc_checker.sv
// Port-level assertions for the descriptor channel controller
`timescale 1ns/1ps

module dmc_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic        pslverr,
  input wire logic        link_in,
  input wire logic        m_req,
  input wire logic        m_we,
  input wire logic [31:0] m_addr,
  input wire logic [31:0] m_wdata,
  input wire logic [1:0]  m_size,
  input wire logic        m_ack,
  input wire logic        link_trig,
  input wire logic        busy
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_req_hold: assert property (m_req && !m_ack |=> m_req
    && $stable(m_addr) && $stable(m_we) && $stable(m_wdata))
    else $error("bus request changed before ack");
  a_req_release: assert property (m_req && m_ack |=> !m_req)
    else $error("bus request held after ack");
  a_req_busy: assert property (m_req |-> busy)
    else $error("bus request while idle");
  a_link_pulse: assert property (link_trig |=> !link_trig)
    else $error("link trigger longer than one cycle");
  a_link_end: assert property ($rose(link_trig) |-> $past(busy))
    else $error("link trigger without a finished loop");
  a_link_start: assert property (link_in && !busy |=> busy)
    else $error("link input did not start a loop");
  a_src_word: assert property (m_req && !m_we && m_size == 2'h2
    |-> m_addr[1:0] == 2'h0)
    else $error("misaligned word read issued");
  a_unmapped_err: assert property (psel && penable && paddr >= 8'h30
    |-> pslverr)
    else $error("unmapped access without error");
endmodule // dmc_checker

bind dmc_channel dmc_checker dmc_checker_inst (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .paddr(paddr),
  .pslverr(pslverr), .link_in(link_in), .m_req(m_req), .m_we(m_we),
  .m_addr(m_addr), .m_wdata(m_wdata), .m_size(m_size), .m_ack(m_ack),
  .link_trig(link_trig), .busy(busy));

// >>> testbench/dmc_mem_model.sv
// Crossbar and memory seen by the channel's bus master port
`timescale 1ns/1ps

module dmc_mem_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        m_req,
  input  wire logic        m_we,
  input  wire logic [31:0] m_addr,
  input  wire logic [31:0] m_wdata,
  input  wire logic        slow,
  output logic             m_ack,
  output logic      [31:0] m_rdata
);
  logic [31:0] mem [logic [31:0]];
  int          wait_q;

  // Read data is scrambled while no request waits for its ack, so stale values never pass
  always @(posedge clk or posedge rst)
    if (rst)
    begin
      m_ack <= 1'b0;
      m_rdata <= 32'h0;
      wait_q <= 0;
    end
    else if (m_req && !m_ack && wait_q < (slow ? 3 : 0))
      wait_q <= wait_q + 1;
    else if (m_req && !m_ack)
    begin
      m_ack <= 1'b1;
      wait_q <= 0;
      if (m_we)
        mem[m_addr] = m_wdata;
      else
        m_rdata <= mem.exists(m_addr) ? mem[m_addr] : ~m_addr;
    end
    else
    begin
      m_ack <= 1'b0;
      m_rdata <= ~m_rdata;
    end
endmodule // dmc_mem_model

// >>> testbench/dmc_channel_tb_top.sv
// Self-checking bench for the descriptor channel controller
`timescale 1ns/1ps

module dmc_channel_tb_top;
  import dmc_pkg::*;
  logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, m_addr, m_wdata, m_rdata, rd;
  logic        pready, pslverr, hw_req = 0, link_in = 0, m_req, m_we;
  logic        m_ack, link_trig, busy, irq, slow = 0, err;
  logic [1:0]  m_size;
  logic [2:0]  link_ch;
  logic [1:0]  bw [3] = '{STALL_NONE, STALL_FOUR_CYCLES, STALL_EIGHT_CYCLES};
  int          st [3] = '{0, 4, 8};
  int          fails = 0, checks_done = 0, cyc = 0, links = 0, l0;
  int          t_rd, gap, gap0, seed = 32'h20415c91;
  logic [31:0] exp_a [$], exp_d [$];
  // Chained descriptor: wraps its destination in 16 bytes, half irq on
  logic [31:0] sgd [8] = '{32'h108, 32'h31c, 32'h0004_0004, 32'h8,
                           32'h0, 32'h0001_0001, 32'h0088_0005, 32'h0};

  dmc_channel #(.DESC_ALIGN(32)) dmc_channel_inst (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hw_req(hw_req), .link_in(link_in), .m_req(m_req),
    .m_we(m_we), .m_addr(m_addr), .m_wdata(m_wdata), .m_size(m_size),
    .m_ack(m_ack), .m_rdata(m_rdata), .link_trig(link_trig),
    .link_ch(link_ch), .busy(busy), .irq(irq));
  dmc_mem_model dmc_mem_model_inst (
    .clk(clk), .rst(rst), .m_req(m_req), .m_we(m_we), .m_addr(m_addr),
    .m_wdata(m_wdata), .slow(slow), .m_ack(m_ack), .m_rdata(m_rdata));

  always #5 clk = ~clk;

  task automatic chk(input string n, input logic [31:0] s, e);
    checks_done++;
    if (s !== e)
    begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic desc(input logic [31:0] s, dd, nb, ml, it, sg, csr);
    apb(1, A_STATUS, 32'h1f);
    apb(1, 8'h00, s);
    apb(1, 8'h04, dd);
    apb(1, 8'h08, 32'h0004_0004);
    apb(1, 8'h0c, nb);
    apb(1, 8'h10, ml);
    apb(1, 8'h14, it);
    apb(1, 8'h1c, sg);
    apb(1, 8'h18, csr);
  endtask

  // Expected writes follow the source data word by word
  task automatic plan(input logic [31:0] s, dd, input int n);
    for (int i = 0; i < n; i += 4)
    begin
      exp_a.push_back(dd + i);
      exp_d.push_back(dmc_mem_model_inst.mem[s + i]);
    end
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
    while (busy !== 1'b0) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask

  // ------------------------------------------------------------------
  // Bus monitor, reference comparison and timeout
  // ------------------------------------------------------------------
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      fails++;
      stop_test();
    end
    if (link_trig === 1'b1)
      links++;
    if (m_req && m_ack && !m_we)
      t_rd = cyc;
    if (m_req && m_ack && m_we)
    begin
      gap = cyc - t_rd;
      if (exp_a.size() == 0)
        chk("stray write", 32'h1, 32'h0);
      else
      begin
        chk("write addr", m_addr, exp_a.pop_front());
        chk("write data", m_wdata, exp_d.pop_front());
      end
    end
  end

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 32; a += 4)
      dmc_mem_model_inst.mem[32'h100 + a] = $random(seed);
    for (int a = 8'h20; a < 8'h30; a += 4)
    begin
      apb(0, 8'(a), 32'h0);
      chk("reset value", rd, 32'h0);
    end
    apb(0, 8'h3c, 32'h0);
    chk("unmapped read", rd, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    // Minor link, negative minor offset rewinds the source
    plan(32'h100, 32'h200, 8);
    desc(32'h100, 32'h200, 8, 32'h800f_fff8, 32'h0002_0002, 0,
         32'h0080_0a23);
    settle();
    chk("minor links", links, 1);
    chk("link chan", {29'h0, link_ch}, 32'h5);
    apb(0, A_REMAIN, 32'h0);
    chk("remaining", rd, 32'h8);
    plan(32'h100, 32'h208, 8);
    slow <= 1'($random(seed));
    @(posedge clk);
    link_in <= 1'b1;
    @(posedge clk);
    link_in <= 1'b0;
    settle();
    chk("last link", links, 2);
    apb(0, A_STATUS, 32'h0);
    chk("major status", rd, 32'h11);
    apb(0, A_REMAIN, 32'h0);
    chk("reloaded", rd, 32'h10);
    chk("irq masked", {31'h0, irq}, 32'h0);
    apb(1, A_MASK, 32'h1);
    @(posedge clk);
    chk("irq on", {31'h0, irq}, 32'h1);
    apb(1, A_STATUS, 32'h1);
    @(posedge clk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    // Link bits are frozen while the completion flag stands
    apb(1, 8'h18, 32'h0080_0a40);
    apb(0, 8'h18, 32'h0);
    chk("link frozen", rd & CSR_LINK_MSK, 32'h0000_0a20);
    apb(1, A_STATUS, 32'h10);
    apb(1, 8'h18, 32'h0080_0a40);
    apb(0, 8'h18, 32'h0);
    chk("link taken", rd & CSR_LINK_MSK, 32'h0000_0a40);
    // Bandwidth stalls, measured against the no-stall case
    slow <= 1'b0;
    for (int b = 0; b < 3; b++)
    begin
      l0 = links;
      plan(32'h100, 32'h300, 4);
      desc(32'h100, 32'h300, 4, 0, 32'h0001_0001, 0,
           32'h0080_0441 | (32'(bw[b]) << CSR_BW));
      settle();
      if (b == 0)
        gap0 = gap;
      chk("stall", gap - gap0, st[b]);
      chk("major link", links - l0, 1);
    end
    // Misaligned source is refused without any access
    desc(32'h102, 32'h300, 4, 0, 32'h0001_0001, 0, 32'h0080_0001);
    settle();
    apb(0, A_STATUS, 32'h0);
    chk("src error", rd & 32'h8, 32'h8);
    apb(1, A_MASK, 32'h8);
    @(posedge clk);
    chk("err irq", {31'h0, irq}, 32'h1);
    // Hardware request with automatic request stop, then pause
    apb(1, A_MASK, 32'h0);
    plan(32'h100, 32'h300, 4);
    desc(32'h100, 32'h300, 4, 0, 32'h0001_0001, 0, 32'h0080_0008);
    apb(1, A_CTRL, 32'h1);
    hw_req <= 1'b1;
    settle();
    apb(0, A_CTRL, 32'h0);
    chk("auto stop", rd, 32'h0);
    repeat (20) @(posedge clk);
    chk("paused", {31'h0, busy}, 32'h0);
    // Disable mid-loop: the write waits until requests are enabled
    plan(32'h104, 32'h304, 4);
    apb(1, A_CTRL, 32'h1);
    apb(1, A_CTRL, 32'h0);
    hw_req <= 1'b0;
    repeat (20) @(posedge clk);
    chk("pause busy", {31'h0, busy}, 32'h1);
    chk("pause held", exp_a.size(), 1);
    apb(1, A_CTRL, 32'h1);
    settle();
    chk("resumed", exp_a.size(), 0);
    // Aligned chain: one idle cycle between fetch and the next loop
    for (int i = 0; i < 8; i++)
      dmc_mem_model_inst.mem[32'h400 + 4 * i] = sgd[i];
    plan(32'h100, 32'h300, 4);
    plan(32'h108, 32'h31c, 4);
    plan(32'h10c, 32'h310, 4);
    desc(32'h100, 32'h300, 4, 0, 32'h0001_0001, 32'h400,
         32'h0080_0011);
    settle();
    settle();
    apb(0, A_STATUS, 32'h0);
    chk("chain status", rd, 32'h12);
    apb(0, 8'h04, 32'h0);
    chk("chain dst", rd, 32'h314);
    // Chained descriptor off its alignment
    plan(32'h100, 32'h300, 4);
    desc(32'h100, 32'h300, 4, 0, 32'h0001_0001, 32'h310, 32'h0080_0011);
    settle();
    apb(0, A_STATUS, 32'h0);
    chk("desc error", rd & 32'h4, 32'h4);
    chk("leftover", exp_a.size(), 0);
    stop_test();
  end
endmodule // dmc_channel_tb_top
